// [ssvic_pkg.sv]
`default_nettype none
package ssvic_pkg;

  localparam int NumSrc = 6;

  // register locations in the data memory map
  localparam logic [7:0] CtrlLowAddr  = 8'h0b;
  localparam logic [7:0] CtrlHighAddr = 8'h1e;
  localparam logic [7:0] CtrlReset    = 8'h00;

  // field positions in the low control register
  localparam int LowMasterBit = 0;
  localparam int LowEnBase    = 1;
  localparam int LowFlagBase  = 4;
  // field positions in the high control register
  localparam int HighEnBase   = 0;
  localparam int HighFlagBase = 4;
  localparam int SrcPerReg    = 3;

  // source index, also priority order (0 is highest)
  localparam int SrcExtA    = 0;
  localparam int SrcExtB    = 1;
  localparam int SrcCountA  = 2;
  localparam int SrcCountB  = 3;
  localparam int SrcTick    = 4;
  localparam int SrcClkTick = 5;

  localparam logic [7:0] VecExtA    = 8'h04;
  localparam logic [7:0] VecExtB    = 8'h08;
  localparam logic [7:0] VecCountA  = 8'h0c;
  localparam logic [7:0] VecCountB  = 8'h10;
  localparam logic [7:0] VecTick    = 8'h14;
  localparam logic [7:0] VecClkTick = 8'h18;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ssvic_reg_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } ssvic_call_type;

  typedef struct packed {
    logic counterAOvf;
    logic counterBOvf;
    logic tickBase;
    logic clockTick;
  } ssvic_int_evt_type;

endpackage
`default_nettype wire

// [ssvic_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module ssvic_ctrl
  import ssvic_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              extIrqPinA,
  input  wire logic              extIrqPinB,
  input  wire ssvic_int_evt_type intEvt,
  input  wire logic              cyclePhaseTwo,
  input  wire logic              stackFull,
  input  wire logic              retFromIrqExec,
  input  wire logic              coreHalted,
  input  wire ssvic_reg_req_type regReq,
  output logic [7:0]             regRdData_q,
  output ssvic_call_type         call_q,
  output logic                   wakeUp_q,
  output logic                   masterIrqEnable_q
);

  function automatic logic [NumSrc-1:0] pickFirst(input logic [NumSrc-1:0] req);
    logic [NumSrc-1:0] oneHot;
    oneHot = '0;
    for (int i = NumSrc - 1; i >= 0; i--) begin
      if (req[i]) begin
        oneHot = '0;
        oneHot[i] = 1'b1;
      end
    end
    return oneHot;
  endfunction

  function automatic logic [7:0] vectorOf(input logic [NumSrc-1:0] oneHot);
    logic [7:0] vec;
    vec = 8'h00;
    if (oneHot[SrcExtA])    vec = VecExtA;
    if (oneHot[SrcExtB])    vec = VecExtB;
    if (oneHot[SrcCountA])  vec = VecCountA;
    if (oneHot[SrcCountB])  vec = VecCountB;
    if (oneHot[SrcTick])    vec = VecTick;
    if (oneHot[SrcClkTick]) vec = VecClkTick;
    return vec;
  endfunction

  function automatic logic [7:0] readReg(input logic [7:0] addr, input logic master_irq_enable,
                                         input logic [NumSrc-1:0] en, input logic [NumSrc-1:0] fl);
    logic [7:0] val;
    val = 8'h00;
    if (addr == CtrlLowAddr) begin
      val[LowMasterBit] = master_irq_enable;
      val[LowEnBase +: SrcPerReg]   = en[0 +: SrcPerReg];
      val[LowFlagBase +: SrcPerReg] = fl[0 +: SrcPerReg];
    end else if (addr == CtrlHighAddr) begin
      val[HighEnBase +: SrcPerReg]   = en[SrcPerReg +: SrcPerReg];
      val[HighFlagBase +: SrcPerReg] = fl[SrcPerReg +: SrcPerReg];
    end
    return val;
  endfunction

  // pin synchronisers; stage one feeds only stage two
  logic pinAMeta_q;
  logic pinASync_q;
  logic pinAPrev_q;
  logic pinBMeta_q;
  logic pinBSync_q;
  logic pinBPrev_q;

  logic [NumSrc-1:0] enable_q;
  logic [NumSrc-1:0] flag_q;
  logic [NumSrc-1:0] flag_d;
  logic [NumSrc-1:0] event_d;
  logic [NumSrc-1:0] grant;
  logic              ackNow;
  logic              wrLow;
  logic              wrHigh;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinAMeta_q <= 1'b1;
      pinASync_q <= 1'b1;
      pinAPrev_q <= 1'b1;
      pinBMeta_q <= 1'b1;
      pinBSync_q <= 1'b1;
      pinBPrev_q <= 1'b1;
    end else begin
      pinAMeta_q <= extIrqPinA;
      pinASync_q <= pinAMeta_q;
      pinAPrev_q <= pinASync_q;
      pinBMeta_q <= extIrqPinB;
      pinBSync_q <= pinBMeta_q;
      pinBPrev_q <= pinBSync_q;
    end
  end

  always_comb begin
    event_d = '0;
    event_d[SrcExtA]    = pinAPrev_q & ~pinASync_q;
    event_d[SrcExtB]    = pinBPrev_q & ~pinBSync_q;
    event_d[SrcCountA]  = intEvt.counterAOvf;
    event_d[SrcCountB]  = intEvt.counterBOvf;
    event_d[SrcTick]    = intEvt.tickBase;
    event_d[SrcClkTick] = intEvt.clockTick;
  end

  assign wrLow  = regReq.wr && (regReq.addr == CtrlLowAddr);
  assign wrHigh = regReq.wr && (regReq.addr == CtrlHighAddr);

  // requests pending before this pulse are judged only on the phase-two pulse
  assign grant  = pickFirst(flag_q & enable_q);
  assign ackNow = cyclePhaseTwo && masterIrqEnable_q && !stackFull && (|grant);

  // new events win over both software and service clears, so none is lost
  always_comb begin
    flag_d = flag_q;
    if (wrLow) begin
      flag_d[0 +: SrcPerReg] = regReq.data[LowFlagBase +: SrcPerReg];
    end
    if (wrHigh) begin
      flag_d[SrcPerReg +: SrcPerReg] = regReq.data[HighFlagBase +: SrcPerReg];
    end
    if (ackNow) begin
      flag_d = flag_d & ~grant;
    end
    flag_d = flag_d | event_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= '0;
    end else begin
      if (wrLow) begin
        enable_q[0 +: SrcPerReg] <= regReq.data[LowEnBase +: SrcPerReg];
      end
      if (wrHigh) begin
        enable_q[SrcPerReg +: SrcPerReg] <= regReq.data[HighEnBase +: SrcPerReg];
      end
    end
  end

  // service clear outranks a same-cycle write or return, blocking nesting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterIrqEnable_q <= 1'b0;
    end else if (ackNow) begin
      masterIrqEnable_q <= 1'b0;
    end else if (retFromIrqExec) begin
      masterIrqEnable_q <= 1'b1;
    end else if (wrLow) begin
      masterIrqEnable_q <= regReq.data[LowMasterBit];
    end
  end

  // core pushes only its program counter on valid, then jumps to vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      call_q <= '0;
    end else begin
      call_q.valid  <= ackNow;
      call_q.vector <= vectorOf(grant);
    end
  end

  // a flag already set before halt cannot wake; only fresh events do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeUp_q <= 1'b0;
    end else begin
      wakeUp_q <= coreHalted && (|(event_d & ~flag_q));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData_q <= CtrlReset;
    end else begin
      regRdData_q <= readReg(regReq.addr, masterIrqEnable_q, enable_q, flag_q);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence sFallA;
    pinAPrev_q && !pinASync_q;
  endsequence

  sequence sFallB;
    pinBPrev_q && !pinBSync_q;
  endsequence

  sequence sServiceStart;
    cyclePhaseTwo && masterIrqEnable_q && !stackFull && (|(flag_q & enable_q));
  endsequence

  a_ack_clears_master: assert property (sServiceStart |=> call_q.valid && !masterIrqEnable_q)
    else $error("master enable not cleared on service");

  a_stack_full_blocks: assert property (stackFull |=> !call_q.valid)
    else $error("acknowledge while stack full");

  a_master_masks_all: assert property (!masterIrqEnable_q |=> !call_q.valid)
    else $error("acknowledge with master enable clear");

  a_only_phase_two: assert property (call_q.valid |-> $past(cyclePhaseTwo))
    else $error("acknowledge outside phase-two pulse");

  a_ext_edge_flag: assert property (sFallA |=> flag_q[SrcExtA])
    else $error("falling edge did not set flag");

  a_ext_b_edge: assert property (sFallB |=> flag_q[SrcExtB])
    else $error("falling edge b did not set flag");

  a_count_a_sets: assert property (intEvt.counterAOvf |=> flag_q[SrcCountA])
    else $error("counter a event lost");

  a_count_b_sets: assert property (intEvt.counterBOvf |=> flag_q[SrcCountB])
    else $error("counter b event lost");

  a_tick_base_sets: assert property (intEvt.tickBase |=> flag_q[SrcTick])
    else $error("tick base event lost");

  a_clock_tick_sets: assert property (intEvt.clockTick |=> flag_q[SrcClkTick])
    else $error("clock tick event lost");

  a_ext_a_vector: assert property (sServiceStart ##0 flag_q[SrcExtA] && enable_q[SrcExtA]
                                   |=> call_q.vector == VecExtA && !flag_q[SrcExtA] || $past(event_d[SrcExtA]))
    else $error("external a service wrong");

  a_clock_tick_last: assert property (sServiceStart ##0 (flag_q & enable_q) == 6'h20
                                      |=> call_q.vector == VecClkTick)
    else $error("clock tick vector wrong");

  // one pattern per priority level: lower sources only win when all above are idle
  a_ext_b_vector: assert property (sServiceStart ##0 (flag_q[1:0] & enable_q[1:0]) == 2'b10
                                   |=> call_q.vector == VecExtB)
    else $error("external b vector wrong");

  a_ext_b_cleared: assert property (sServiceStart ##0 (flag_q[1:0] & enable_q[1:0]) == 2'b10
                                    |=> !flag_q[SrcExtB] || $past(event_d[SrcExtB]))
    else $error("external b flag not cleared");

  a_count_a_vector: assert property (sServiceStart ##0 (flag_q[2:0] & enable_q[2:0]) == 3'b100
                                     |=> call_q.vector == VecCountA)
    else $error("counter a vector wrong");

  a_count_a_cleared: assert property (sServiceStart ##0 (flag_q[2:0] & enable_q[2:0]) == 3'b100
                                      |=> !flag_q[SrcCountA] || $past(event_d[SrcCountA]))
    else $error("counter a flag not cleared");

  a_count_b_vector: assert property (sServiceStart ##0 (flag_q[3:0] & enable_q[3:0]) == 4'b1000
                                     |=> call_q.vector == VecCountB)
    else $error("counter b vector wrong");

  a_count_b_cleared: assert property (sServiceStart ##0 (flag_q[3:0] & enable_q[3:0]) == 4'b1000
                                      |=> !flag_q[SrcCountB] || $past(event_d[SrcCountB]))
    else $error("counter b flag not cleared");

  a_tick_vector: assert property (sServiceStart ##0 (flag_q[4:0] & enable_q[4:0]) == 5'b10000
                                  |=> call_q.vector == VecTick)
    else $error("tick base vector wrong");

  a_tick_cleared: assert property (sServiceStart ##0 (flag_q[4:0] & enable_q[4:0]) == 5'b10000
                                   |=> !flag_q[SrcTick] || $past(event_d[SrcTick]))
    else $error("tick base flag not cleared");

  a_clock_tick_cleared: assert property (sServiceStart ##0 (flag_q & enable_q) == 6'h20
                                         |=> !flag_q[SrcClkTick] || $past(event_d[SrcClkTick]))
    else $error("clock tick flag not cleared");

  a_enable_blocks: assert property (cyclePhaseTwo && masterIrqEnable_q && !(|(flag_q & enable_q))
                                    |=> !call_q.valid)
    else $error("acknowledge without enabled request");

  a_valid_one_cycle: assert property (call_q.valid |=> !call_q.valid)
    else $error("acknowledge longer than one cycle");

  a_master_holds: assert property (masterIrqEnable_q && !ackNow && !wrLow |=> masterIrqEnable_q)
    else $error("master enable dropped on its own");

  // a plain return has no port, so only return_from_irq_instr or a write may raise the master enable
  a_master_stays_low: assert property (!masterIrqEnable_q && !retFromIrqExec && !wrLow
                                       |=> !masterIrqEnable_q)
    else $error("master enable rose without cause");

  a_write_sets_master: assert property (wrLow && regReq.data[LowMasterBit] && !ackNow
                                        |=> masterIrqEnable_q)
    else $error("software could not set master enable");

  a_low_read_master: assert property ($past(regReq.addr) == CtrlLowAddr
                                      |-> regRdData_q[LowMasterBit] == $past(masterIrqEnable_q))
    else $error("master enable not readable");

  a_top_bit_zero: assert property (!regRdData_q[7])
    else $error("bit 7 not zero");

  a_high_bit3_zero: assert property ($past(regReq.addr) == CtrlHighAddr |-> !regRdData_q[3])
    else $error("high register bit 3 not zero");

  a_wake_ext_a: assert property (sFallA ##0 (coreHalted && !flag_q[SrcExtA]) |=> wakeUp_q)
    else $error("no wake on external a edge");

  a_wake_ext_b: assert property (sFallB ##0 (coreHalted && !flag_q[SrcExtB]) |=> wakeUp_q)
    else $error("no wake on external b edge");

  a_wake_count_a: assert property (coreHalted && intEvt.counterAOvf && !flag_q[SrcCountA] |=> wakeUp_q)
    else $error("no wake on counter a");

  a_wake_count_b: assert property (coreHalted && intEvt.counterBOvf && !flag_q[SrcCountB] |=> wakeUp_q)
    else $error("no wake on counter b");

  a_wake_tick_base: assert property (coreHalted && intEvt.tickBase && !flag_q[SrcTick] |=> wakeUp_q)
    else $error("no wake on tick base");

  a_no_wake_awake: assert property (!coreHalted |=> !wakeUp_q)
    else $error("wake while running");

  a_return_sets: assert property (retFromIrqExec && !ackNow |=> masterIrqEnable_q)
    else $error("return did not set master enable");

  a_flag_holds: assert property (flag_q[SrcCountA] && !ackNow && !wrLow |=> flag_q[SrcCountA])
    else $error("flag dropped without service or clear");

  a_flag_while_masked: assert property (!masterIrqEnable_q && intEvt.tickBase |=> flag_q[SrcTick])
    else $error("event lost while masked");

  a_wake_event: assert property (coreHalted && intEvt.clockTick && !flag_q[SrcClkTick] |=> wakeUp_q)
    else $error("no wake on fresh event");

endmodule
`default_nettype wire

// [ssvic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssvic_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       callValid,
  input  wire logic [1:0] op,
  output logic            cyclePhaseTwo,
  output logic            stackFull,
  output logic            retFromIrqExec
);
  logic [2:0] depth_q;
  logic [1:0] phase_q;
  // op: 1 push, 2 plain return, 3 return from interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
      cyclePhaseTwo <= 1'b0;
      retFromIrqExec <= 1'b0;
      depth_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
      cyclePhaseTwo <= (phase_q == 2'h1);
      retFromIrqExec <= (op == 2'h3);
      depth_q <= depth_q + 3'(callValid) + 3'(op == 2'h1) - 3'(op[1]);
    end
  end
  assign stackFull = (depth_q == 3'h6);
endmodule
`default_nettype wire

// [six_source_vectored_interrupt_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module six_source_vectored_interrupt_ctrl_tb;
  import ssvic_pkg::*;
  logic              clk = 0, rst = 1, pinA = 1, pinB = 1, halted = 0;
  logic [1:0]        op = 0;
  ssvic_int_evt_type evt = '0;
  ssvic_reg_req_type req = '0;
  ssvic_call_type    call;
  logic [7:0]        rdData;
  logic              wake, master, ph2, full, return_from_irq_instr;
  int                num_errors = 0, checks_done = 0;
  logic [7:0]        vecs [6] = '{VecExtA, VecExtB, VecCountA, VecCountB, VecTick, VecClkTick};
  always #4 clk = ~clk;
  ssvic_ctrl uut (.clk(clk), .rst(rst), .extIrqPinA(pinA), .extIrqPinB(pinB), .intEvt(evt),
    .cyclePhaseTwo(ph2), .stackFull(full), .retFromIrqExec(return_from_irq_instr), .coreHalted(halted), .regReq(req),
    .regRdData_q(rdData), .call_q(call), .wakeUp_q(wake), .masterIrqEnable_q(master));
  ssvic_core_model core_m (.clk(clk), .rst(rst), .callValid(call.valid), .op(op),
    .cyclePhaseTwo(ph2), .stackFull(full), .retFromIrqExec(return_from_irq_instr));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, a, d};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{1'b0, a, 8'h00};
    @(posedge clk);
    #1 chk("reg", e, rdData);
  endtask
  task automatic pulse(input ssvic_int_evt_type v);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= '0;
  endtask
  task automatic core(input logic [1:0] o);
    @(posedge clk) op <= o;
    @(posedge clk) op <= 2'h0;
  endtask
  task automatic serve(input logic [7:0] v);
    for (int k = 0; k < 16 && call.valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("valid", 8'h01, {7'h0, call.valid});
    chk("vector", v, call.vector);
    chk("master", 8'h00, {7'h0, master});
  endtask
  task automatic return_from_irq_instr_op();
    core(2'h3);
    @(posedge clk);
    #1 chk("master", 8'h01, {7'h0, master});
  endtask
  task automatic noack();
    repeat (12) begin
      @(posedge clk);
      #1 chk("valid", 8'h00, {7'h0, call.valid});
    end
  endtask
  task automatic t_layout();
    rd(CtrlLowAddr, 8'h00);
    rd(CtrlHighAddr, 8'h00);
    wr(CtrlLowAddr, 8'hfe);
    wr(CtrlHighAddr, 8'hff);
    wr(8'h0c, 8'hff);
    rd(CtrlLowAddr, 8'h7e);
    rd(CtrlHighAddr, 8'h77);
    rd(8'h0c, 8'h00);
    wr(CtrlLowAddr, 8'h00);
    wr(CtrlHighAddr, 8'h00);
    $display("test layout done");
  endtask
  task automatic t_priority();
    @(posedge clk) pinA <= 1'b0;
    pinB <= 1'b0;
    pulse(4'hf);
    repeat (5) @(posedge clk);
    rd(CtrlLowAddr, 8'h70);
    rd(CtrlHighAddr, 8'h70);
    wr(CtrlHighAddr, 8'h77);
    noack();
    wr(CtrlLowAddr, 8'h7f);
    foreach (vecs[i]) begin
      serve(vecs[i]);
      return_from_irq_instr_op();
    end
    rd(CtrlLowAddr, 8'h0f);
    rd(CtrlHighAddr, 8'h07);
    $display("test priority done");
  endtask
  task automatic t_stack();
    repeat (6) core(2'h1);
    pulse(4'h8);
    noack();
    core(2'h2);
    serve(VecCountA);
    return_from_irq_instr_op();
    repeat (5) core(2'h2);
    $display("test stack done");
  endtask
  task automatic t_nest();
    pulse(4'h8);
    serve(VecCountA);
    pulse(4'h2);
    noack();
    rd(CtrlHighAddr, 8'h27);
    wr(CtrlLowAddr, 8'h0f);
    serve(VecTick);
    return_from_irq_instr_op();
    return_from_irq_instr_op();
    $display("test nest done");
  endtask
  task automatic t_wake();
    wr(CtrlLowAddr, 8'h00);
    wr(CtrlHighAddr, 8'h00);
    @(posedge clk) halted <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pulse(ssvic_int_evt_type'(4'h1 << i));
      #1;
      for (int k = 0; k < 4 && wake !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      chk("wake", 8'h01, {7'h0, wake});
    end
    @(posedge clk) pinA <= 1'b1;
    repeat (4) @(posedge clk);
    pinA <= 1'b0;
    for (int k = 0; k < 8 && wake !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("wake pin", 8'h01, {7'h0, wake});
    rd(CtrlHighAddr, 8'h70);
    @(posedge clk) halted <= 1'b0;
    $display("test wake done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_layout();
    t_priority();
    t_stack();
    t_nest();
    t_wake();
    complete_run();
  end
  // whole run is a few hundred cycles
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
